// file: logic/ipc_pkg.sv
package ipc_pkg;
    localparam int PRIO_W = 3;
    localparam int DSCP_W = 6;
    localparam int QUEUE_W = 3;
    localparam int NUM_PRIO = 8;
    localparam int NUM_DSCP = 64;
    localparam int NUM_PORTS = 8;
    localparam int PORT_W = 3;
    // Register byte offsets
    localparam logic [11:0] OFS_CTRL = 12'h000;
    localparam logic [11:0] OFS_GLOBAL_FB = 12'h004;
    localparam logic [11:0] OFS_STATUS = 12'h008;
    localparam logic [11:0] OFS_PORT_FB = 12'h040;
    localparam logic [11:0] OFS_QMAP = 12'h080;
    localparam logic [11:0] OFS_DSCP_MAP = 12'h100;
    // Control register fields
    localparam int CTRL_DSCP_EN_BIT = 0;
    localparam int CTRL_DSCP_OVER_TAG_BIT = 1;
    localparam int CTRL_QMAP_RESTORE_BIT = 2;
    // Type-of-service byte: code point sits in the upper six bits
    localparam int TOS_DSCP_LSB = 2;
    localparam logic [PRIO_W-1:0] FB_PRIO_RST = 3'h0;
    localparam logic [NUM_PRIO*QUEUE_W-1:0] QMAP_RST =
        {3'h7, 3'h6, 3'h5, 3'h4, 3'h3, 3'h1, 3'h0, 3'h2};
    typedef enum logic [1:0] {
        IPC_SRC_FALLBACK = 2'b00,
        IPC_SRC_TAG = 2'b01,
        IPC_SRC_DSCP = 2'b10
    } ipc_src_type;
endpackage

// file: logic/ipc_classifier.sv
`timescale 1ns/1ps
module ipc_classifier #(
    parameter int NPORTS = ipc_pkg::NUM_PORTS
) (
    input wire logic clk_sys_i,
    input wire logic rstn_i,
    // APB slave
    input wire logic psel_i,
    input wire logic penable_i,
    input wire logic pwrite_i,
    input wire logic [11:0] paddr_i,
    input wire logic [31:0] pwdata_i,
    input wire logic [3:0] pstrb_i,
    output logic [31:0] prdata_o,
    output logic pready_o,
    output logic pslverr_o,
    // Frame descriptor from parser
    input wire logic frm_valid_i,
    input wire logic [ipc_pkg::PORT_W-1:0] frm_port_i,
    input wire logic frm_tagged_i,
    input wire logic [ipc_pkg::PRIO_W-1:0] frm_tag_prio_i,
    input wire logic frm_is_ip_i,
    input wire logic [7:0] frm_tos_i,
    // Result to egress queue selector
    output logic cls_valid_o,
    output logic [ipc_pkg::PRIO_W-1:0] cls_prio_o,
    output logic [ipc_pkg::QUEUE_W-1:0] egress_queue_index_o,
    output logic [1:0] cls_src_o
);
    import ipc_pkg::*;

    logic dscp_en_q;
    logic dscp_over_tag_q;
    logic [PRIO_W-1:0] global_fallback_setting_q;
    logic [PRIO_W-1:0] port_fb_q [NPORTS];
    logic [PRIO_W-1:0] dscp_map_q [NUM_DSCP];
    logic [NUM_PRIO*QUEUE_W-1:0] qmap_q;
    logic [31:0] frame_cnt_q;
    ipc_src_type src_d;
    logic [PRIO_W-1:0] prio_d;
    logic [DSCP_W-1:0] dscp;
    logic [PRIO_W-1:0] dscp_prio;
    logic [PRIO_W-1:0] fb_prio;
    logic [PRIO_W-1:0] port_idx;
    logic wr_en;
    logic rd_en;
    logic addr_ok;
    logic [31:0] rdata_d;

    // Whether an address is a word inside a window of registers, and its word index
    function automatic logic in_window(input logic [11:0] a,
                                       input logic [11:0] base,
                                       input int words);
        return (a >= base) && (a < base + 12'(words * 4)) &&
               (a[1:0] == 2'b00);
    endfunction

    function automatic logic [5:0] word_idx(input logic [11:0] a,
                                            input logic [11:0] base);
        logic [11:0] off;
        off = a - base;
        return off[7:2];
    endfunction

    // APB: zero wait states, every access completes in its access phase
    assign pready_o = 1'b1;
    assign wr_en = psel_i && penable_i && pwrite_i && pstrb_i[0];
    assign rd_en = psel_i && !penable_i && !pwrite_i;

    always_comb begin
        addr_ok = 1'b0;
        if ((paddr_i == OFS_CTRL) || (paddr_i == OFS_GLOBAL_FB) ||
            (paddr_i == OFS_STATUS)) begin
            addr_ok = 1'b1;
        end
        if (in_window(paddr_i, OFS_PORT_FB, NPORTS) ||
            in_window(paddr_i, OFS_QMAP, NUM_PRIO) ||
            in_window(paddr_i, OFS_DSCP_MAP, NUM_DSCP)) begin
            addr_ok = 1'b1;
        end
    end

    assign pslverr_o = psel_i && penable_i && !addr_ok;

    // Control: code-point enable and precedence mode
    always_ff @(posedge clk_sys_i or negedge rstn_i) begin
        if (!rstn_i) begin
            dscp_en_q <= 1'b0;
            dscp_over_tag_q <= 1'b0;
        end else if (wr_en && paddr_i == OFS_CTRL) begin
            dscp_en_q <= pwdata_i[CTRL_DSCP_EN_BIT];
            dscp_over_tag_q <= pwdata_i[CTRL_DSCP_OVER_TAG_BIT];
        end
    end

    // Last global value written, kept for readback
    always_ff @(posedge clk_sys_i or negedge rstn_i) begin
        if (!rstn_i) begin
            global_fallback_setting_q <= FB_PRIO_RST;
        end else if (wr_en && paddr_i == OFS_GLOBAL_FB) begin
            global_fallback_setting_q <= pwdata_i[PRIO_W-1:0];
        end
    end

    // Per-port fallback; a global write overwrites every port at once
    genvar gp;
    generate
        for (gp = 0; gp < NPORTS; gp++) begin : g_port
            always_ff @(posedge clk_sys_i or negedge rstn_i) begin
                if (!rstn_i) begin
                    port_fb_q[gp] <= FB_PRIO_RST;
                end else if (wr_en && paddr_i == OFS_GLOBAL_FB) begin
                    port_fb_q[gp] <= pwdata_i[PRIO_W-1:0];
                end else if (wr_en && in_window(paddr_i, OFS_PORT_FB, NPORTS)
                             && word_idx(paddr_i, OFS_PORT_FB) == 6'(gp)) begin
                    // Writing zero is the clear action
                    port_fb_q[gp] <= pwdata_i[PRIO_W-1:0];
                end
            end
        end
    endgenerate

    // Code-point table; not reset, software loads it before enabling
    always_ff @(posedge clk_sys_i) begin
        if (wr_en && in_window(paddr_i, OFS_DSCP_MAP, NUM_DSCP)) begin
            dscp_map_q[word_idx(paddr_i, OFS_DSCP_MAP)] <=
                pwdata_i[PRIO_W-1:0];
        end
    end

    // Queue table with restore to defaults in one write
    always_ff @(posedge clk_sys_i or negedge rstn_i) begin
        if (!rstn_i) begin
            qmap_q <= QMAP_RST;
        end else if (wr_en && paddr_i == OFS_CTRL &&
                     pwdata_i[CTRL_QMAP_RESTORE_BIT]) begin
            qmap_q <= QMAP_RST;
        end else if (wr_en && in_window(paddr_i, OFS_QMAP, NUM_PRIO)) begin
            qmap_q[word_idx(paddr_i, OFS_QMAP)*QUEUE_W +: QUEUE_W] <=
                pwdata_i[QUEUE_W-1:0];
        end
    end

    // Frame counter for status readback
    always_ff @(posedge clk_sys_i or negedge rstn_i) begin
        if (!rstn_i) begin
            frame_cnt_q <= 32'h0000_0000;
        end else if (frm_valid_i) begin
            frame_cnt_q <= frame_cnt_q + 32'h0000_0001;
        end
    end

    // Read mux, captured in setup so data is from a flop in access phase
    always_comb begin
        rdata_d = 32'h0000_0000;
        if (paddr_i == OFS_CTRL) begin
            rdata_d[CTRL_DSCP_EN_BIT] = dscp_en_q;
            rdata_d[CTRL_DSCP_OVER_TAG_BIT] = dscp_over_tag_q;
        end else if (paddr_i == OFS_GLOBAL_FB) begin
            rdata_d[PRIO_W-1:0] = global_fallback_setting_q;
        end else if (paddr_i == OFS_STATUS) begin
            rdata_d = frame_cnt_q;
        end else if (in_window(paddr_i, OFS_PORT_FB, NPORTS)) begin
            rdata_d[PRIO_W-1:0] =
                port_fb_q[PORT_W'(word_idx(paddr_i, OFS_PORT_FB))];
        end else if (in_window(paddr_i, OFS_QMAP, NUM_PRIO)) begin
            rdata_d[QUEUE_W-1:0] =
                qmap_q[word_idx(paddr_i, OFS_QMAP)*QUEUE_W +: QUEUE_W];
        end else if (in_window(paddr_i, OFS_DSCP_MAP, NUM_DSCP)) begin
            rdata_d[PRIO_W-1:0] = dscp_map_q[word_idx(paddr_i, OFS_DSCP_MAP)];
        end
    end

    always_ff @(posedge clk_sys_i or negedge rstn_i) begin
        if (!rstn_i) begin
            prdata_o <= 32'h0000_0000;
        end else if (rd_en) begin
            prdata_o <= rdata_d;
        end
    end

    // Classification
    assign dscp = frm_tos_i[7:TOS_DSCP_LSB];
    assign dscp_prio = dscp_map_q[dscp];
    // Out-of-range port numbers fall back to port 0 rather than X
    assign port_idx = (32'(frm_port_i) < NPORTS) ? frm_port_i : '0;
    assign fb_prio = port_fb_q[port_idx];

    always_comb begin
        src_d = IPC_SRC_FALLBACK;
        prio_d = fb_prio;
        if (dscp_en_q && frm_is_ip_i) begin
            if (frm_tagged_i && !dscp_over_tag_q) begin
                src_d = IPC_SRC_TAG;
                prio_d = frm_tag_prio_i;
            end else begin
                src_d = IPC_SRC_DSCP;
                prio_d = dscp_prio;
            end
        end else if (frm_tagged_i) begin
            src_d = IPC_SRC_TAG;
            prio_d = frm_tag_prio_i;
        end
    end

    always_ff @(posedge clk_sys_i or negedge rstn_i) begin
        if (!rstn_i) begin
            cls_valid_o <= 1'b0;
            cls_prio_o <= FB_PRIO_RST;
            egress_queue_index_o <= '0;
            cls_src_o <= IPC_SRC_FALLBACK;
        end else begin
            cls_valid_o <= frm_valid_i;
            if (frm_valid_i) begin
                cls_prio_o <= prio_d;
                egress_queue_index_o <=
                    qmap_q[prio_d*QUEUE_W +: QUEUE_W];
                cls_src_o <= src_d;
            end
        end
    end
endmodule

// file: tb/ipc_classifier_sva.sv
`timescale 1ns/1ps
module ipc_classifier_sva (
    input wire logic clk_sys_i,
    input wire logic rstn_i,
    input wire logic psel_i,
    input wire logic penable_i,
    input wire logic pslverr_o,
    input wire logic frm_valid_i,
    input wire logic frm_tagged_i,
    input wire logic [2:0] frm_tag_prio_i,
    input wire logic frm_is_ip_i,
    input wire logic cls_valid_o,
    input wire logic [2:0] cls_prio_o,
    input wire logic [2:0] egress_queue_index_o,
    input wire logic [1:0] cls_src_o
);
    default clocking @(posedge clk_sys_i); endclocking
    default disable iff (!rstn_i);
    sequence tag_l2_s; frm_valid_i && frm_tagged_i && !frm_is_ip_i; endsequence
    sequence tag_out_s; cls_valid_o && cls_src_o == 2'h1; endsequence
    resp_lat_a: assert property (frm_valid_i |=> cls_valid_o)
        else $error("no result one cycle after frame");
    no_spur_a: assert property (!frm_valid_i |=> !cls_valid_o)
        else $error("result without frame");
    tag_keep_a: assert property (tag_l2_s |=> tag_out_s and
        (cls_prio_o == $past(frm_tag_prio_i))) else $error("tag lost");
    fb_untag_a: assert property (frm_valid_i && !frm_tagged_i
        && !frm_is_ip_i |=> cls_src_o == 2'h0) else $error("no fallback");
    tag_nofb_a: assert property (frm_valid_i && frm_tagged_i
        |=> cls_src_o != 2'h0) else $error("tagged frame got fallback");
    ip_untag_a: assert property (frm_valid_i && frm_is_ip_i
        && !frm_tagged_i |=> cls_src_o != 2'h1) else $error("bad source");
    result_hold_a: assert property (!frm_valid_i |=> $stable(cls_prio_o)
        && $stable(egress_queue_index_o)) else $error("result moved");
    err_phase_a: assert property (pslverr_o |-> psel_i && penable_i)
        else $error("error outside access phase");
endmodule

// file: tb/ipc_parser_model.sv
`timescale 1ns/1ps
module ipc_parser_model (
    input wire logic clk_sys_i,
    output logic frm_valid_o,
    output logic [2:0] frm_port_o,
    output logic frm_tagged_o,
    output logic [2:0] frm_tag_prio_o,
    output logic frm_is_ip_o,
    output logic [7:0] frm_tos_o
);
    initial begin
        frm_valid_o = 1'b0;
        {frm_port_o, frm_tagged_o, frm_tag_prio_o} = '0;
        {frm_is_ip_o, frm_tos_o} = '0;
    end
    // Fields are scrambled outside the valid cycle, so late sampling shows
    // Layout: port 15:13, tagged 12, tag prio 11:9, ip 8, tos 7:0
    task automatic send(input logic [15:0] f);
        @(posedge clk_sys_i);
        frm_valid_o <= 1'b1;
        {frm_port_o, frm_tagged_o, frm_tag_prio_o} <= f[15:9];
        {frm_is_ip_o, frm_tos_o} <= f[8:0];
        @(posedge clk_sys_i);
        frm_valid_o <= 1'b0;
        {frm_port_o, frm_tagged_o, frm_tag_prio_o} <= ~f[15:9];
        {frm_is_ip_o, frm_tos_o} <= ~f[8:0];
    endtask
endmodule

// file: tb/tb_ingress_priority_classifier.sv
`timescale 1ns/1ps
module tb_ingress_priority_classifier;
    import ipc_pkg::*;
    typedef struct packed {
        logic [2:0] ctrl;
        logic [15:0] frm;
        logic [7:0] exp;
    } ipc_row_type;
    logic clk_sys_i, rstn_i, psel_i, penable_i, pwrite_i, pready_o, er;
    logic [11:0] paddr_i;
    logic [31:0] pwdata_i, prdata_o, rd;
    logic [3:0] pstrb_i = 4'hF;
    logic pslverr_o, frm_valid_i, frm_tagged_i, frm_is_ip_i, cls_valid_o;
    logic [2:0] frm_port_i, frm_tag_prio_i, cls_prio_o, egress_queue_index_o;
    logic [7:0] frm_tos_i;
    logic [1:0] cls_src_o;
    int fails = 0, checks_done = 0, cyc = 0;
    // ctrl | port,tagged,tag prio,ip,tos | prio,queue,src
    ipc_row_type rows [11] = '{
        '{3'h1, 16'h0000, 8'hB4},
        '{3'h1, 16'hC000, 8'hB4},
        '{3'h1, 16'h4000, 8'hD8},
        '{3'h1, 16'hB600, 8'h6D},
        '{3'h1, 16'h41B8, 8'hE2},
        '{3'h1, 16'hC1BB, 8'hE2},
        '{3'h1, 16'h73B8, 8'h21},
        '{3'h3, 16'h73B8, 8'hE2},
        '{3'h0, 16'h41B8, 8'hD8},
        '{3'h0, 16'h19B8, 8'h91},
        '{3'h5, 16'h41B8, 8'hFE}};
    initial begin
        clk_sys_i = 1'b0;
        forever #2 clk_sys_i = ~clk_sys_i;
    end
    ipc_classifier ipc_classifier_i (.clk_sys_i, .rstn_i, .psel_i, .penable_i,
        .pwrite_i, .paddr_i, .pwdata_i, .pstrb_i, .prdata_o, .pready_o,
        .pslverr_o, .frm_valid_i, .frm_port_i, .frm_tagged_i, .frm_tag_prio_i,
        .frm_is_ip_i, .frm_tos_i, .cls_valid_o, .cls_prio_o,
        .egress_queue_index_o, .cls_src_o);
    ipc_parser_model ipc_parser_model_i (.clk_sys_i, .frm_valid_o(frm_valid_i),
        .frm_port_o(frm_port_i), .frm_tagged_o(frm_tagged_i),
        .frm_tag_prio_o(frm_tag_prio_i), .frm_is_ip_o(frm_is_ip_i),
        .frm_tos_o(frm_tos_i));
    task automatic chk(input string n, input logic [31:0] e,
                       input logic [31:0] g);
        checks_done++;
        if (g !== e) begin
            fails++;
            $display("mismatch %s expected %0h seen %0h", n, e, g);
        end
    endtask
    task automatic apb(input logic w, input logic [11:0] a,
                       input logic [31:0] d);
        @(posedge clk_sys_i);
        {psel_i, penable_i, pwrite_i, paddr_i, pwdata_i} <= {2'h2, w, a, d};
        @(posedge clk_sys_i);
        penable_i <= 1'b1;
        do @(posedge clk_sys_i); while (pready_o !== 1'b1);
        rd = prdata_o;
        er = pslverr_o;
        {psel_i, penable_i} <= 2'h0;
    endtask
    task automatic frame(input ipc_row_type r);
        ipc_parser_model_i.send(r.frm);
        #1;
        chk("valid", 32'h1, cls_valid_o);
        chk("result", r.exp, {cls_prio_o, egress_queue_index_o, cls_src_o});
    endtask
    task automatic report_and_stop;
        $display("checks %0d mismatches %0d", checks_done, fails);
        if (fails == 0 && checks_done > 0) $display("ALL CHECKS OK");
        else $display("CHECKS NOT OK");
        $finish;
    endtask
    always @(posedge clk_sys_i) begin
        cyc++;
        if (cyc == 5000) begin
            fails++;
            report_and_stop();
        end
    end
    initial begin
        {rstn_i, psel_i, penable_i, pwrite_i, paddr_i, pwdata_i} = '0;
        repeat (10) @(posedge clk_sys_i);
        rstn_i <= 1'b1;
        apb(1'b1, OFS_GLOBAL_FB, 32'h5);
        apb(1'b1, OFS_PORT_FB + 12'h008, 32'h6);
        apb(1'b1, OFS_DSCP_MAP + 12'h0B8, 32'h7);
        apb(1'b1, OFS_QMAP + 12'h01C, 32'h0);
        foreach (rows[i]) begin
            apb(1'b1, OFS_CTRL, {29'h0, rows[i].ctrl});
            frame(rows[i]);
        end
        // Unmapped word between status and port block
        apb(1'b0, 12'h00C, 32'h0);
        chk("unmapped", 32'h1, {31'h0, er});
        chk("unmapped data", 32'h0, rd);
        // Second reset in mid-run must bring defaults back
        rstn_i <= 1'b0;
        repeat (2) @(posedge clk_sys_i);
        rstn_i <= 1'b1;
        for (int p = 0; p < 8; p++) begin
            apb(1'b0, OFS_QMAP + 12'(4 * p), 32'h0);
            chk("queue map", {29'h0, QMAP_RST[3*p+:3]}, rd);
        end
        frame('{3'h0, 16'h2000, 8'h08});
        report_and_stop();
    end
endmodule
bind ipc_classifier ipc_classifier_sva ipc_classifier_sva_i (.clk_sys_i,
    .rstn_i, .psel_i, .penable_i, .pslverr_o, .frm_valid_i, .frm_tagged_i,
    .frm_tag_prio_i, .frm_is_ip_i, .cls_valid_o, .cls_prio_o,
    .egress_queue_index_o, .cls_src_o);
